// *** design/ppu_top.sv ***
// Purpose: pulse pattern unit, sixteen outputs in four 4-bit groups
// Assumes: classic wishbone slave, timer compare-match pulses as inputs
// Notes: non-overlap and inverted output are not provided
//
// Contract
// RL1: sixteen pulse outputs in four 4-bit groups, each triggered independently.
// RL2: output updates are timed only by timer unit compare-match events.
// RL3: on trigger, next-data bits with enable set copy to output level.
// RL4: bits with enable cleared keep their output level on trigger.
// RL5: writes to output level bits are ignored while their enable is set.
// RL6: output level bits accept writes while their enable is clear.
// RL7: software sets pin direction so pulse value reaches the pin.
// RL8: next-data addresses depend on shared or split trigger per group pair.
// RL9: 2-bit select per group, codes 00..11 pick timer channels 0..3.
// RL10: split trigger gives each nibble its own address; unused nibble reads ones.
// RL11: reset clears all enable and output level bits.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppu_top
  import ppu_pkg::*;
#(
  parameter int GROUPS = PPU_GROUPS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // timer unit compare-match pulses, channels 3..0
  input wire logic [PPU_TIMER_CH-1:0] timer_match_i,
  // pulse outputs and enables (pin direction is outside)
  output logic [GROUPS*PPU_GRP_W-1:0] pulse_out_o,
  output logic [GROUPS*PPU_GRP_W-1:0] pulse_en_o
);
  localparam int W = GROUPS * PPU_GRP_W;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [W-1:0] enable_q;
  logic [W-1:0] level_q;
  logic [W-1:0] next_q;
  logic [7:0] tsel_q;
  // group triggers of the last cycle, read back as status
  logic [GROUPS-1:0] trig_q;
  logic [GROUPS-1:0] trig_d;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  ppu_wb_req_t req;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // expand per-group flags to a per-bit mask
  function automatic logic [15:0] grp_mask(input logic [3:0] g);
    grp_mask = {{4{g[3]}}, {4{g[2]}}, {4{g[1]}}, {4{g[0]}}};
  endfunction : grp_mask
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  wire bus_req = req.cyc && req.stb && !ack_q && !err_q;
  wire wr_b0 = bus_req && req.we && req.sel[0];
  wire [7:0] wbyte = req.dat[7:0];
  // pairs share a trigger when their select codes agree
  wire pair_hi_same = tsel_q[7:6] == tsel_q[5:4];  // see RL8
  wire pair_lo_same = tsel_q[3:2] == tsel_q[1:0];  // see RL8
  wire hit_nde_up = req.adr == PPU_ADDR_NDE_UP;
  wire hit_nde_lo = req.adr == PPU_ADDR_NDE_LO;
  wire hit_lvl_up = req.adr == PPU_ADDR_LVL_UP;
  wire hit_lvl_lo = req.adr == PPU_ADDR_LVL_LO;
  wire hit_nd_up = req.adr == PPU_ADDR_ND_UP;
  wire hit_nd_lo = req.adr == PPU_ADDR_ND_LO;
  wire hit_nd_up_a = req.adr == PPU_ADDR_ND_UP_ALT;
  wire hit_nd_lo_a = req.adr == PPU_ADDR_ND_LO_ALT;
  wire hit_tsel = req.adr == PPU_ADDR_TRIG_SEL;
  wire hit_stat = req.adr == PPU_ADDR_STATUS;
  wire hit_any = hit_nde_up | hit_nde_lo | hit_lvl_up | hit_lvl_lo | hit_nd_up |
                 hit_nd_lo | hit_nd_up_a | hit_nd_lo_a | hit_tsel | hit_stat;
  // next-data byte write masks per address and trigger mode
  wire [7:0] nd_up_wm = hit_nd_up ? (pair_hi_same ? 8'hff : 8'hf0) :  // see RL10
                        (hit_nd_up_a && !pair_hi_same) ? 8'h0f : 8'h00;
  wire [7:0] nd_lo_wm = hit_nd_lo ? (pair_lo_same ? 8'hff : 8'hf0) :  // see RL10
                        (hit_nd_lo_a && !pair_lo_same) ? 8'h0f : 8'h00;
  wire [15:0] nd_wm = wr_b0 ? {nd_up_wm, nd_lo_wm} : 16'h0000;
  // next-data read views: unused nibble reads as ones
  wire [7:0] nd_up_rd = pair_hi_same ? next_q[15:8] : {next_q[15:12], PPU_NIB_ONES};
  wire [7:0] nd_lo_rd = pair_lo_same ? next_q[7:0] : {next_q[7:4], PPU_NIB_ONES};
  wire [7:0] nd_up_ra = pair_hi_same ? 8'h00 : {PPU_NIB_ONES, next_q[11:8]};
  wire [7:0] nd_lo_ra = pair_lo_same ? 8'h00 : {PPU_NIB_ONES, next_q[3:0]};
  wire [7:0] rbyte = hit_nde_up ? enable_q[15:8] : hit_nde_lo ? enable_q[7:0] :
                     hit_lvl_up ? level_q[15:8] : hit_lvl_lo ? level_q[7:0] :
                     hit_nd_up ? nd_up_rd : hit_nd_lo ? nd_lo_rd :
                     hit_nd_up_a ? nd_up_ra : hit_nd_lo_a ? nd_lo_ra :
                     hit_tsel ? tsel_q : hit_stat ? {4'h0, trig_q} : 8'h00;
  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  ppu_trig_sel #(.GROUPS(GROUPS)) u_sel (
    .match_i(timer_match_i),  // see RL2
    .sel_i(tsel_q),
    .trig_o(trig_d)
  );
  // ---------------------------------------------------------------
  // level update: trigger copy on enabled bits, software on others
  // ---------------------------------------------------------------
  wire [W-1:0] trig_bits = grp_mask(trig_d);  // see RL1
  wire [W-1:0] copy_m = trig_bits & enable_q;  // see RL3
  wire [W-1:0] lvl_wm = (wr_b0 && hit_lvl_up) ? {8'hff, 8'h00} :
                        (wr_b0 && hit_lvl_lo) ? {8'h00, 8'hff} : 16'h0000;
  wire [W-1:0] sw_m = lvl_wm & ~enable_q;  // see RL5
  // copy and software write never collide: writes reach disabled bits only
  wire [W-1:0] level_d = (level_q & ~(copy_m | sw_m)) |  // see RL4
                         (next_q & copy_m) | ({wbyte, wbyte} & sw_m);  // see RL6
  wire [W-1:0] next_d = (next_q & ~nd_wm) | ({wbyte, wbyte} & nd_wm);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // enables, next data and selects move only on a bus write or reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= PPU_RST_ENABLE;  // see RL11
      level_q <= PPU_RST_LEVEL;  // see RL11
      next_q <= PPU_RST_NEXT;
      tsel_q <= PPU_RST_TRIG_SEL;
      trig_q <= '0;
    end else begin
      level_q <= level_d;
      next_q <= next_d;
      trig_q <= trig_d;
      if (wr_b0 && hit_nde_up) enable_q[15:8] <= wbyte;
      if (wr_b0 && hit_nde_lo) enable_q[7:0] <= wbyte;
      if (wr_b0 && hit_tsel) tsel_q <= wbyte;
    end
  end
  // bus answer: one cycle after request, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req && hit_any;
      err_q <= bus_req && !hit_any;
      rdat_q <= {24'h00_0000, rbyte};
    end
  end
  // pins follow the level register; enables mirror the enable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_out_o <= PPU_RST_LEVEL;
      pulse_en_o <= PPU_RST_ENABLE;
    end else begin
      pulse_out_o <= level_d;
      pulse_en_o <= enable_q;  // see RL7
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // level register, trigger and bus answer checks
  chk_copy_enabled: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL3
    copy_m != '0 |=> ((level_q & $past(copy_m)) == ($past(next_q) & $past(copy_m))))
    else $error("enabled bit missed trigger copy");
  chk_hold_disabled: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL4
    (sw_m == '0) |=> ((level_q & ~$past(enable_q)) == ($past(level_q) & ~$past(enable_q))))
    else $error("disabled bit changed without write");
  chk_ro_enabled: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL5
    (copy_m == '0) |=> ((level_q & $past(enable_q)) == ($past(level_q) & $past(enable_q))))
    else $error("enabled bit changed without trigger");
  chk_sw_write: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL6
    (wr_b0 && hit_lvl_lo && enable_q[7:0] == 8'h00) |=> level_q[7:0] == $past(wbyte))
    else $error("level write not taken");
  chk_reset_clear: assert property (@(posedge clk_i)  // see RL11
    rst_i |=> (enable_q == '0 && level_q == '0))
    else $error("reset did not clear");
  chk_trig_sel: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL9
    trig_d[3] == timer_match_i[tsel_q[7:6]])
    else $error("group 3 trigger mis-selected");
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_split_ones: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL10
    (!pair_lo_same && bus_req && !req.we && hit_nd_lo) |=> wb_dat_o[3:0] == 4'hf)
    else $error("unused nibble not ones");
  chk_group_local: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL1
    trig_bits != '0 |=>
    ((level_q ^ $past(level_q)) & $past(enable_q) & ~$past(trig_bits)) == '0)
    else $error("enabled bit moved outside its triggered group");
  // ---------------------------------------------------------------
  // bus-side checks
  // ---------------------------------------------------------------
  // a mapped request is answered by ack on the very next edge
  chk_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && hit_any) |=> (wb_ack_o && !wb_err_o))
    else $error("mapped request not acknowledged");
  // an unmapped request must leave the enable, next-data and select registers alone
  chk_err_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !hit_any) |=> (wb_err_o && enable_q == $past(enable_q) &&
    next_q == $past(next_q) && tsel_q == $past(tsel_q)))
    else $error("unmapped access changed state");
  // shared pair: the alternate next-data address is dead for writes
  chk_alt_ignored: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL8
    (wr_b0 && hit_nd_up_a && pair_hi_same) |=> next_q[15:8] == $past(next_q[15:8]))
    else $error("alternate next-data write taken in shared mode");
  // split pair: the unused nibble of the main address ignores writes
  chk_split_keep: assert property (@(posedge clk_i) disable iff (rst_i)  // see RL10
    (wr_b0 && hit_nd_lo && !pair_lo_same) |=> next_q[3:0] == $past(next_q[3:0]))
    else $error("unused nibble was written");
endmodule : ppu_top
`default_nettype wire

// *** design/ppu_pkg.sv ***
// Purpose: shared constants and types for the pulse pattern unit
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: all register offsets are word aligned
package ppu_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PPU_ADDR_NDE_UP = 8'h00;
  localparam logic [7:0] PPU_ADDR_NDE_LO = 8'h04;
  localparam logic [7:0] PPU_ADDR_LVL_UP = 8'h08;
  localparam logic [7:0] PPU_ADDR_LVL_LO = 8'h0c;
  localparam logic [7:0] PPU_ADDR_ND_UP = 8'h10;  // shared trigger: full byte
  localparam logic [7:0] PPU_ADDR_ND_LO = 8'h14;
  localparam logic [7:0] PPU_ADDR_ND_UP_ALT = 8'h18;  // split trigger: low nibble
  localparam logic [7:0] PPU_ADDR_ND_LO_ALT = 8'h1c;
  localparam logic [7:0] PPU_ADDR_TRIG_SEL = 8'h20;
  localparam logic [7:0] PPU_ADDR_STATUS = 8'h24;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] PPU_RST_ENABLE = 16'h0000;
  localparam logic [15:0] PPU_RST_LEVEL = 16'h0000;
  localparam logic [15:0] PPU_RST_NEXT = 16'h0000;
  localparam logic [7:0] PPU_RST_TRIG_SEL = 8'hff;
  localparam logic [3:0] PPU_NIB_ONES = 4'hf;
  localparam int PPU_GROUPS = 4;
  localparam int PPU_GRP_W = 4;
  localparam int PPU_SEL_W = 2;
  localparam int PPU_TIMER_CH = 4;
  // ---------------------------------------------------------------
  // bus carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ppu_wb_req_t;
endpackage : ppu_pkg

// *** design/ppu_trig_sel.sv ***
// Purpose: picks one timer compare-match per output group
// Assumes: compare-match inputs are single-cycle pulses
// Notes: purely combinational selection, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module ppu_trig_sel
  import ppu_pkg::*;
#(
  parameter int GROUPS = 4
) (
  // timer compare-match pulses
  input wire logic [PPU_TIMER_CH-1:0] match_i,
  // per-group 2-bit select codes
  input wire logic [GROUPS*PPU_SEL_W-1:0] sel_i,
  // per-group trigger
  output logic [GROUPS-1:0] trig_o
);
  // ---------------------------------------------------------------
  // code 00..11 picks timer channel 0..3
  // ---------------------------------------------------------------
  for (genvar g = 0; g < GROUPS; g++) begin : g_sel
    assign trig_o[g] = match_i[sel_i[g*PPU_SEL_W +: PPU_SEL_W]];  // see RL9
  end
endmodule : ppu_trig_sel
`default_nettype wire

// *** dv/ppu_pin_model.sv ***
// Purpose: board pins fed by the pulse outputs
// Assumes: pins not set to output float to a pull-up
// Notes: behavioural only
`timescale 1ns/1ps
`default_nettype none
module ppu_pin_model (
  // unit side
  input wire logic [15:0] level_i,
  input wire logic [15:0] dir_i,
  // board side
  output logic [15:0] pin_o
);
  // pulse value reaches a pin only when its direction is output
  assign pin_o = (level_i & dir_i) | ~dir_i;
endmodule : ppu_pin_model
`default_nettype wire

// *** dv/ppu_top_tb_top.sv ***
// Purpose: self-checking bench for the pulse pattern unit
// Assumes: one-cycle wishbone answer, registered outputs
// Notes: expected answers queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ppu_top_tb_top;
  import ppu_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err;
  logic [3:0] sel = 4'h0, tm = 4'h0;
  logic [7:0] adr = 8'h00, v, m, d, lv;
  logic [31:0] dat = 32'h0, rdat;
  logic [15:0] pout, pen, pins;
  logic [15:0] dir = 16'hffff;
  logic [33:0] exp_q[$], e;
  logic [1:0] c;
  int failures = 0, total_checks = 0, r;
  always #5 clk_i = ~clk_i;
  ppu_top u_ppu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .timer_match_i(tm), .pulse_out_o(pout),
    .pulse_en_o(pen));
  ppu_pin_model u_ppu_pin_model (.level_i(pout), .dir_i(dir), .pin_o(pins));
  // ----------------------------------------------------------------
  // bus driver and trigger pulses
  // ----------------------------------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [7:0] x);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h0, x};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(34'h0);
    bus(1'b1, a, x);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back({2'b10, 24'h0, x});
    bus(1'b0, a, 8'h00);
  endtask : rd
  task trig(input logic [3:0] x);
    tm <= x;
    @(posedge clk_i);
    tm <= 4'h0;
    @(posedge clk_i);
  endtask : trig
  // monitor: each answer takes the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 || err === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(err, e[32])
      if (e[33]) `CHK(rdat, e[31:0])
    end
  end
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    r = $urandom(32'h9bf9d093);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values and unmapped place
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h20, 8'hff);
    exp_q.push_back({2'b01, 32'h0});
    bus(1'b0, 8'h3c, 8'h00);
    $display("test 1 done");
    // level writes with enable clear and set
    v = $urandom();
    wr(8'h0c, v);
    rd(8'h0c, v);
    wr(8'h04, 8'h0f);
    wr(8'h0c, ~v);
    lv = (v & 8'h0f) | (~v & 8'hf0);
    rd(8'h0c, lv);
    $display("test 2 done");
    // split triggers, every select code
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      m = $urandom();
      d = $urandom();
      wr(8'h04, m);
      wr(8'h20, {4'hf, ~c, c});
      wr(8'h1c, {4'h0, d[3:0]});
      wr(8'h14, {d[7:4], 4'h0});
      rd(8'h14, {d[7:4], 4'hf});
      rd(8'h1c, {4'hf, d[3:0]});
      trig(4'h1 << c);
      lv = (lv & ~(m & 8'h0f)) | (d & m & 8'h0f);
      rd(8'h0c, lv);
      trig(4'h1 << ~c);
      lv = (lv & ~(m & 8'hf0)) | (d & m & 8'hf0);
      rd(8'h0c, lv);
      `CHK(pins[7:0], lv)
    end
    $display("test 3 done");
    // shared trigger, full byte next data
    d = $urandom();
    wr(8'h20, 8'h00);
    wr(8'h00, 8'hff);
    wr(8'h10, d);
    wr(8'h18, ~d);
    rd(8'h18, 8'h00);
    rd(8'h10, d);
    trig(4'h1);
    rd(8'h08, d);
    `CHK(pen[15:8], 8'hff)
    `CHK(pen[7:0], m)
    `CHK(pout[15:8], d)
    $display("test 4 done");
    // pins set as inputs float high, then reset in mid-run
    dir <= 16'h00ff;
    @(posedge clk_i);
    `CHK(pins[15:8], 8'hff)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(pout, 16'h0000)
    `CHK(pen, 16'h0000)
    rd(8'h00, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h20, 8'hff);
    $display("test 5 done");
    stop_test();
  end
endmodule : ppu_top_tb_top
`default_nettype wire
